// ---- bench/count_source.sv ----
// timebase side: makes a burst of falling edges on the counted signal
// assumes: pclk from the bench; the request is held until busy rises
`timescale 1ns/1ps
`default_nettype none

module count_source (
    // clock
    input wire logic pclk,
    // request
    input wire logic go,
    input wire logic [15:0] n,
    // counted signal
    output logic count_in,
    output logic busy
);
    logic [15:0] left_q;

    initial begin
        count_in = 1'b1;
        busy = 1'b0;
        left_q = '0;
    end

    // one low cycle and one high cycle per edge, idle high
    always @(posedge pclk) begin
        if (go && !busy) begin
            left_q <= n;
            busy <= (n != 16'h0000);
        end else if (busy) begin
            count_in <= !count_in;
            if (!count_in) begin
                left_q <= left_q - 16'h0001;
                if (left_q == 16'h0001) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule // count_source

`default_nettype wire

// ---- bench/lcd_decade_counter_test.sv ----
// self-checking bench of the decade counter over apb and its pins
// assumes: core files compiled first; count_source drives count_in
`timescale 1ns/1ps
`default_nettype none
`include "lcd_counter_map.svh"

module lcd_decade_counter_test;
    import lcd_counter_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, s;
    logic count_in, count_hold_n, reset_n, store_n, carry_out;
    logic blank_chain_in, blank_chain_out, osc_ext_sel, osc_ext_in;
    logic bti, bto, boe, go, busy;
    logic [15:0] n_r;
    logic [`NUM_SEGS-1:0] seg;
    logic [32:0] q[$];
    logic [6:0] font [0:9] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
        7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    int n_errors = 0;
    int checks = 0;
    int c = 0;
    localparam int OSC_HALF_SIM = 2;

    lcd_decade_counter #(.OSC_HALF(OSC_HALF_SIM), .SENSE_CYC(10)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_in(count_in),
        .count_hold_n(count_hold_n), .reset_n(reset_n), .store_n(store_n),
        .carry_out(carry_out), .blank_chain_in(blank_chain_in),
        .blank_chain_out(blank_chain_out), .osc_ext_sel(osc_ext_sel),
        .osc_ext_in(osc_ext_in), .backplane_terminal_i(bti),
        .backplane_terminal_o(bto), .backplane_terminal_oe(boe), .seg(seg));

    count_source u_src (.pclk(pclk), .go(go), .n(n_r),
        .count_in(count_in), .busy(busy));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [16:0] tobcd(input int v);
        logic [16:0] r;
        r = '0;
        r[16] = (v >= 10000);
        for (int i = 0; i < 4; i++) begin
            r[4*i+:4] = 4'((v / (10 ** i)) % 10);
        end
        return r;
    endfunction

    // lit pattern expected on the glass, with leading zero blanking
    function automatic logic [28:0] pat(input logic [16:0] v, input logic blk);
        logic [28:0] p;
        logic lead;
        p = '0;
        p[28] = v[16];
        lead = blk && !v[16];
        for (int i = 3; i >= 0; i--) begin
            lead = lead && (v[4*i+:4] == 4'h0) && i > 0 || lead && v == '0;
            if (!lead) p[7*i+:7] = font[v[4*i+:4]];
        end
        return p;
    endfunction

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rc(input int v);
        apb(1'b0, `REG_COUNT, '0, {16'h0000, tobcd(v)});
    endtask

    task automatic pulses(input int k);
        @(posedge pclk);
        go <= 1'b1;
        n_r <= 16'(k);
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask

    // compares lit segments away from a backplane edge
    task automatic lit(input logic [28:0] exp);
        logic b;
        do begin
            @(negedge pclk);
            b = boe ? bto : bti;
            repeat (3) @(negedge pclk);
        end while (b !== (boe ? bto : bti));
        check(33'(seg ^ {29{b}}), 33'(exp));
        // hand back on a rising edge so the caller's inputs change there
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (pready === 1'b1 && psel && !pwrite && q.size() > 0) begin
            check({pslverr, prdata}, q.pop_front());
        end
    end

    initial begin
        pclk = 1'b0;
        forever #50 pclk = !pclk;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        int k;
        logic b0;
        {presetn, psel, penable, pwrite, go, osc_ext_sel, bti} = '0;
        {paddr, pwdata, n_r} = '0;
        {count_hold_n, reset_n, blank_chain_in, osc_ext_in} = 4'hf;
        store_n = 1'b0;
        s = 32'h0000_4c05;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rc(0);
        apb(1'b0, 12'h00c, '0, {1'b1, 32'h0000_0000});
        lit('0);
        check(33'(blank_chain_out), 33'h1);
        blank_chain_in <= 1'b0;
        lit(pat(17'h0, 1'b0));
        blank_chain_in <= 1'b1;
        pulses(12);
        c = 12;
        rc(c);
        lit(pat(tobcd(c), 1'b1));
        apb(1'b1, `REG_CTRL, 32'h0000_0001, '0);
        pulses(5);
        rc(c);
        apb(1'b1, `REG_CTRL, 32'h0000_0000, '0);
        count_hold_n <= 1'b0;
        pulses(5);
        rc(c);
        count_hold_n <= 1'b1;
        store_n <= 1'b1;
        pulses(3);
        c += 3;
        rc(c);
        lit(pat(tobcd(12), 1'b1));
        store_n <= 1'b0;
        // align to a backplane edge, then time one half period
        k = 0;
        b0 = bto;
        while (bto === b0 && k < 600) begin
            @(posedge pclk);
            k++;
        end
        k = 0;
        b0 = bto;
        while (bto === b0 && k < 600) begin
            @(posedge pclk);
            k++;
        end
        check(33'(k), 33'(`BP_DIVIDE * OSC_HALF_SIM));
        pulses(9999 - c);
        c = 9999;
        rc(c);
        check(33'(carry_out), 33'h1);
        pulses(1);
        c++;
        rc(c);
        check(33'(carry_out), 33'h0);
        pulses(1);
        c++;
        rc(c);
        lit(pat(tobcd(c), 1'b1));
        check(33'(blank_chain_out), 33'h0);
        reset_n <= 1'b0;
        repeat (2) @(posedge pclk);
        reset_n <= 1'b1;
        c = 0;
        rc(c);
        for (int i = 0; i < 3; i++) begin
            s = lfsr(s);
            k = int'(s[3:0]) + 1;
            pulses(k);
            c += k;
            rc(c);
        end
        osc_ext_sel <= 1'b1;
        osc_ext_in <= 1'b0;
        repeat (5) @(posedge pclk);
        osc_ext_in <= 1'b1;
        repeat (3) @(posedge pclk);
        check(33'(boe), 33'h1);
        osc_ext_in <= 1'b0;
        repeat (15) @(posedge pclk);
        check(33'(boe), 33'h0);
        for (int i = 0; i < 4; i++) begin
            s = lfsr(s);
            bti <= s[0];
            // the outside backplane stays no faster than our own
            repeat (`BP_DIVIDE * OSC_HALF_SIM) @(posedge pclk);
            lit(pat(tobcd(c), 1'b1));
        end
        tally_and_finish();
    end
endmodule // lcd_decade_counter_test

`default_nettype wire

// ---- core/lcd_counter_map.svh ----
// offsets, field positions and timing counts of the decade counter
// assumes: included by its bare name from the package and the core
`ifndef LCD_COUNTER_MAP_SVH
`define LCD_COUNTER_MAP_SVH

`define CLK_PERIOD_NS 100
`define OSC_FREQ_HZ 19000
`define CLK_FREQ_HZ 10000000
`define OSC_HALF_CYC (`CLK_FREQ_HZ / (2 * `OSC_FREQ_HZ))
`define BP_DIVIDE 126
`define BP_HALF_OSC (`BP_DIVIDE / 2)
`define DISABLE_SENSE_NS 1000
`define DISABLE_SENSE_CYC ((`DISABLE_SENSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define NUM_DECADES 4
`define NUM_SEGS 29
`define CARRY_DIGIT 4'h8

`define REG_COUNT 12'h000
`define REG_CTRL 12'h004
`define REG_STATUS 12'h008

`define CTRL_SW_HOLD 0
`define CTRL_RESET 32'h0000_0000
`define STAT_SLAVE 0
`define STAT_BP 1
`define STAT_BLANK 2
`define CNT_HALF 16

`endif

// ---- core/lcd_counter_pkg.sv ----
// types shared by the decade counter core
// assumes: lcd_counter_map.svh on the include path
`include "lcd_counter_map.svh"

package lcd_counter_pkg;
    typedef struct packed {
        logic half;
        logic [`NUM_DECADES-1:0][3:0] dec;
    } count_s;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_s;

    typedef enum logic {BP_MASTER, BP_SLAVE} bp_mode_e;
endpackage

// ---- core/lcd_decade_counter.sv ----
// four and a half decade counter with static lcd segment drive and apb
// assumes: all pins synchronous to pclk; pullups on the open-high inputs
// are outside this core, so an open pin arrives here as a 1
//
// Function
// - one backplane, 29 separate segment outputs
// - oscillator held low: slave to backplane terminal
// - backplane is oscillator divided by 126
// - free-running oscillator near 19 kHz
// - ignore oscillator lows shorter than one microsecond
// - four resettable ripple-carry decimal decades
// - count on each falling count-input edge
// - carry falls on wrap 9999 to 0000
// - carry-clocked half-digit flop stays set
// - decades keep counting after half-digit set
// - reset low clears decades and half-digit
// - hold freezes first stage, clock untouched
// - each decade has its own segment decoder
// - store low follows decoders, high holds
// - blanking input high blanks leading zeros
// - input low or half set shows zeros
// - blank output high only when all blanked
// - control inputs read high when open
// - displayed range reaches 19999
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_counter_map.svh"

module lcd_decade_counter
    import lcd_counter_pkg::*;
#(
    parameter int OSC_HALF = `OSC_HALF_CYC,
    parameter int SENSE_CYC = `DISABLE_SENSE_CYC
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter control
    input wire logic count_in,
    input wire logic count_hold_n,
    input wire logic reset_n,
    input wire logic store_n,
    output logic carry_out,
    // blanking chain
    input wire logic blank_chain_in,
    output logic blank_chain_out,
    // oscillator node
    input wire logic osc_ext_sel,
    input wire logic osc_ext_in,
    // backplane terminal and segments
    input wire logic backplane_terminal_i,
    output logic backplane_terminal_o,
    output logic backplane_terminal_oe,
    output logic [`NUM_SEGS-1:0] seg
);

    localparam int HW = $clog2(OSC_HALF + 1);
    localparam int SW = $clog2(SENSE_CYC + 1);
    localparam int DW = $clog2(`BP_HALF_OSC + 1);

    function automatic logic [6:0] seg7(input logic [3:0] v);
        // bits g..a
        case (v)
            4'h0: seg7 = 7'h3F;
            4'h1: seg7 = 7'h06;
            4'h2: seg7 = 7'h5B;
            4'h3: seg7 = 7'h4F;
            4'h4: seg7 = 7'h66;
            4'h5: seg7 = 7'h6D;
            4'h6: seg7 = 7'h7D;
            4'h7: seg7 = 7'h07;
            4'h8: seg7 = 7'h7F;
            4'h9: seg7 = 7'h6F;
            default: seg7 = 7'h00;
        endcase
    endfunction

    count_s cnt_q;
    logic count_prev_q;
    logic carry_q;
    logic [31:0] ctrl_q;
    logic fall;
    logic inc;
    logic [`NUM_DECADES:0] rip;
    logic [`NUM_DECADES-1:0] blank;
    logic [`NUM_SEGS-1:0] pattern;
    logic [`NUM_SEGS-1:0] latch_q;
    logic blank_latch_q;
    logic [HW-1:0] osc_cnt_q;
    logic osc_int_q;
    logic osc_prev_q;
    logic osc_node;
    logic osc_rise;
    logic [SW-1:0] low_cnt_q;
    bp_mode_e mode_q;
    logic [DW-1:0] div_q;
    logic bp_int_q;
    logic phase;
    apb_req_s req;

    // counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_prev_q <= 1'b0;
        end else begin
            count_prev_q <= count_in;
        end
    end

    assign fall = count_prev_q & ~count_in;
    // first stage frozen by its enable, the sampling clock keeps running
    assign inc = fall & count_hold_n & ~ctrl_q[`CTRL_SW_HOLD];
    assign rip[0] = inc;

    generate
        for (genvar i = 0; i < `NUM_DECADES; i++) begin : g_dec
            // ripple carry out of a decade at its 9 to 0 step
            assign rip[i+1] = rip[i] & (cnt_q.dec[i] == 4'h9);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q.dec[i] <= 4'h0;
                end else if (!reset_n) begin
                    cnt_q.dec[i] <= 4'h0;
                end else if (rip[i]) begin
                    cnt_q.dec[i] <= (cnt_q.dec[i] == 4'h9) ? 4'h0 :
                        cnt_q.dec[i] + 4'h1;
                end
            end
        end
    endgenerate

    // carry is the top decade msb, so it falls on 9999 to 0000
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_q <= 1'b0;
        end else if (!reset_n) begin
            carry_q <= 1'b0;
        end else begin
            carry_q <= cnt_q.dec[3] >= `CARRY_DIGIT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q.half <= 1'b0;
        end else if (!reset_n) begin
            cnt_q.half <= 1'b0;
        end else if (carry_q && cnt_q.dec[3] < `CARRY_DIGIT) begin
            cnt_q.half <= 1'b1;
        end
    end

    // decode, blank and store
    assign blank[3] = blank_chain_in & ~cnt_q.half &
        (cnt_q.dec[3] == 4'h0);
    generate
        for (genvar i = 0; i < `NUM_DECADES; i++) begin : g_seg
            if (i < `NUM_DECADES - 1) begin : g_chain
                assign blank[i] = blank[i+1] &
                    (cnt_q.dec[i] == 4'h0);
            end
            assign pattern[7*i +: 7] = seg7(cnt_q.dec[i]) &
                ~{7{blank[i]}};
        end
    endgenerate
    assign pattern[`NUM_SEGS-1] = cnt_q.half;

    // open inputs arrive high, so an open store pin holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= '0;
            blank_latch_q <= 1'b0;
        end else if (!store_n) begin
            latch_q <= pattern;
            blank_latch_q <= blank[0];
        end
    end

    // oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= '0;
            osc_int_q <= 1'b0;
        end else if (osc_cnt_q == HW'(OSC_HALF - 1)) begin
            osc_cnt_q <= '0;
            osc_int_q <= ~osc_int_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 1'b1;
        end
    end

    assign osc_node = osc_ext_sel ? osc_ext_in : osc_int_q;
    assign osc_rise = osc_node & ~osc_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_node;
        end
    end

    // only a low lasting the full sense time selects slave mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_q <= '0;
            mode_q <= BP_MASTER;
        end else if (!osc_ext_sel || osc_ext_in) begin
            low_cnt_q <= '0;
            mode_q <= BP_MASTER;
        end else if (low_cnt_q == SW'(SENSE_CYC - 1)) begin
            mode_q <= BP_SLAVE;
        end else begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            bp_int_q <= 1'b0;
        end else if (osc_rise) begin
            if (div_q == DW'(`BP_HALF_OSC - 1)) begin
                div_q <= '0;
                bp_int_q <= ~bp_int_q;
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // drivers
    assign phase = (mode_q == BP_SLAVE) ? backplane_terminal_i : bp_int_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg <= '0;
            backplane_terminal_o <= 1'b0;
            backplane_terminal_oe <= 1'b1;
            carry_out <= 1'b0;
            blank_chain_out <= 1'b0;
        end else begin
            seg <= latch_q ^ {`NUM_SEGS{phase}};
            backplane_terminal_o <= bp_int_q;
            backplane_terminal_oe <= (mode_q == BP_MASTER);
            carry_out <= carry_q;
            blank_chain_out <= blank_latch_q;
        end
    end

    // apb slave: answer on the second access cycle
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            ctrl_q <= `CTRL_RESET;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= '0;
            if (req.addr == `REG_COUNT) begin
                if (!req.write) begin
                    prdata <= {15'h0000, cnt_q.half, cnt_q.dec};
                end
            end else if (req.addr == `REG_CTRL) begin
                if (req.write) begin
                    ctrl_q <= {31'h0000_0000, req.wdata[`CTRL_SW_HOLD]};
                end else begin
                    prdata <= ctrl_q;
                end
            end else if (req.addr == `REG_STATUS) begin
                if (!req.write) begin
                    prdata <= {29'h0000_0000, blank_latch_q, phase,
                        mode_q == BP_SLAVE};
                end
            end else begin
                pslverr <= 1'b1;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // checks
    a_hold_freezes: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!count_hold_n && reset_n) |=> $stable(cnt_q.dec))
        else $error("count moved while held");

    a_count_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        (inc && reset_n && cnt_q.dec[0] != 4'h9)
        |=> cnt_q.dec[0] == $past(cnt_q.dec[0]) + 4'h1)
        else $error("count did not advance by one");

    a_reset_clears: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reset_n |=> (cnt_q.dec == '0 && !cnt_q.half))
        else $error("reset did not clear counter");

    a_carry_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        (inc && reset_n && cnt_q.dec == 16'h9999)
        |-> ##2 $fell(carry_q))
        else $error("carry did not fall on wrap");

    a_half_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($fell(carry_q) && reset_n && $past(reset_n)) |-> cnt_q.half)
        else $error("half digit not set by carry");

    a_half_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(cnt_q.half) |-> $fell(carry_q))
        else $error("half digit set without a carry fall");

    a_half_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cnt_q.half && reset_n) |=> cnt_q.half)
        else $error("half digit lost without reset");

    a_store_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        store_n |=> $stable(latch_q))
        else $error("segment latch moved while holding");

    a_blank_empty: assert property (
        @(posedge pclk) disable iff (!presetn)
        blank_latch_q |-> latch_q == '0)
        else $error("blank chain out with a lit segment");

    a_slave_sense: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(osc_ext_sel && !osc_ext_in) ##0
        (osc_ext_sel && !osc_ext_in)[*8] |-> mode_q == BP_MASTER)
        else $error("short oscillator low disabled backplane");

    a_slave_enter: assert property (
        @(posedge pclk) disable iff (!presetn)
        (osc_ext_sel && !osc_ext_in)[*8] ##1
        (osc_ext_sel && !osc_ext_in)[*4] |-> mode_q == BP_SLAVE)
        else $error("long oscillator low did not select slave mode");

    a_slave_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mode_q == BP_SLAVE) |=> (!backplane_terminal_oe &&
        seg == ($past(latch_q) ^ {`NUM_SEGS{$past(backplane_terminal_i)}})))
        else $error("slave mode drove backplane or wrong phase");

    a_seg_phase: assert property (
        @(posedge pclk) disable iff (!presetn)
        backplane_terminal_oe |->
        seg == ($past(latch_q) ^ {`NUM_SEGS{backplane_terminal_o}}))
        else $error("segment phase wrong against own backplane");

endmodule // lcd_decade_counter

`default_nettype wire
